// *** hw/fphs_top.sv ***
// Purpose: Write protection, identifier locking, transfer pause and status of a serial flash.
// Assumes: Classic Wishbone slave on clk_i (40 MHz); link pins are asynchronous and synchronised.
// Notes: nv_init_i models a factory initialisation; rst_i is the power-on reset and spares storage
//        that must persist.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fphs_defines.svh"

// Notes on behaviour
// [R1] Forty-bit permanent lock register: eight parameter blocks plus each larger block.
// [R2] A one in the permanent register forces and holds the matching write-lock bit.
// [R3] Later permanent writes only change positions still zero.
// [R4] Writing zero leaves both the permanent register and the map unchanged.
// [R5] Lock-down active: permanent register writes are ignored until power cycle.
// [R6] The protect pin acts only in single and dual lane mode with io_config_bit zero.
// [R7] With protect_pin_enable zero the protect pin is ignored.
// [R8] protect_pin_enable is non-volatile, factory zero, stays set across power cycles.
// [R9] The protect pin never affects program or erase array writes.
// [R10] io_config_bit one overrides protect_pin_enable and disables the pin.
// [R11] Pin low with enable one and io_config_bit zero rejects map writes.
// [R12] Hardware protection also refuses configuration writes; otherwise they are allowed.
// [R13] Lock-down forbids map writes regardless of pin or configuration bits.
// [R14] 2 KByte identifier space; first 64 bits are factory fixed and unwritable.
// [R15] After the identifier lock command every identifier program is rejected.
// [R16] No part of the identifier space can be erased.
// [R17] The pause pin works in single and dual lane mode only, never in quad; the code also ignores it while io_config_bit is one.
// [R18] Pause is entered and left only while the serial clock is low.
// [R19] While paused the serial output floats and clock and input are ignored.
// [R20] Chip select high during pause resets logic; resume needs pin high first.
// [R21] Status bits 0 and 7 both show busy and are readable meanwhile.
// [R22] Status bits 1 to 6 as mapped; bit 6 reads zero; identifier lock persists.
// [R23] Lock-down status sets on the lock-down command, clears only at power-up.
// [R24] Permanent register, pin enable and identifier lock survive power-on reset.
module fphs_top #(
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic nv_init_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic hold_n_i,
   input wire logic wp_n_i,
   output logic so_hiz_o,
   output logic link_active_o,
   output logic logic_reset_o,
   output logic hw_protect_o
);
   import fphs_pkg::*;

   // UNIQUE_ID is an arbitrary stand-in for the factory segment.
   fphs_state_t q;
   fphs_state_t d;
   logic [7:0] uid_mem [0:`FPHS_UID_BYTES-1];
   logic [`FPHS_SYNC_W-1:0] pins_s;
   logic s_sck;
   logic s_cs_n;
   logic s_hold_n;
   logic s_wp_n;
   logic [`FPHS_BPM_W-1:0] plr_map;
   logic [`FPHS_BPM_W-1:0] bpm_eff;
   logic [31:0] wmask;
   logic [7:0] status;
   logic [7:0] uid_rd;
   logic take;
   logic commit;
   logic hw_prot;
   logic hold_en;
   logic uid_factory;
   logic uid_prog_ok;

   fphs_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({wp_n_i, hold_n_i, cs_n_i, sck_i}),
      .sync_o(pins_s)
   );

   assign s_sck = pins_s[0];
   assign s_cs_n = pins_s[1];
   assign s_hold_n = pins_s[2];
   assign s_wp_n = pins_s[3];

   // Parameter blocks own two map bits each (write lock even, read lock odd); larger blocks one.
   genvar gi;
   generate
      for (gi = 0; gi < `FPHS_BPM_W; gi = gi + 1) begin : g_map
         if (gi < 2 * `FPHS_PARAM_BLOCKS) begin : g_param
            if (gi % 2 == 0) begin : g_wr
               assign plr_map[gi] = q.plr[gi/2]; // [R1] [R2]
            end else begin : g_rd
               assign plr_map[gi] = 1'b0;
            end
         end else begin : g_large
            assign plr_map[gi] = q.plr[gi-`FPHS_PARAM_BLOCKS]; // [R1] [R2]
         end
      end
   endgenerate

   assign bpm_eff = q.bpm | plr_map; // [R2]
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign status = {q.busy, 1'b0, q.uid_lock, q.lockdown, q.psus, q.esus, q.write_enable_latch, q.busy}; // [R21] [R22]
   // Busy and the array path never look at the pin, so array writes are unaffected.
   assign hw_prot = !q.io_config_bit && !q.quad && q.protect_pin_enable && !s_wp_n; // [R6] [R7] [R10] [R11] [R9]
   assign hold_en = !q.io_config_bit && !q.quad; // [R17]
   assign take = wb_cyc_i && wb_stb_i && !q.ack;
   assign commit = wb_cyc_i && wb_stb_i && q.ack && wb_we_i;
   assign uid_factory = q.uid_addr < `FPHS_UID_FACTORY_BYTES;
   assign uid_rd = uid_factory ? UNIQUE_ID[{q.uid_addr[2:0], 3'b000} +: 8] : uid_mem[q.uid_addr];
   assign uid_prog_ok = commit && wb_adr_i == `FPHS_OFF_UID_DATA && wb_sel_i[0] && !q.uid_lock
                        && !uid_factory; // [R14] [R15]

   always_comb begin
      d = q;
      d.lreset = 1'b0;
      d.hwp = hw_prot;
      d.ack = take;
      d.bpm = q.bpm | plr_map; // [R2]
      if (take) begin
         if (wb_we_i) begin
            d.dat = 32'h0000_0000;
         end else if (wb_adr_i == `FPHS_OFF_STATUS) begin
            d.dat = {24'h00_0000, status}; // [R21]
         end else if (wb_adr_i == `FPHS_OFF_CFG) begin
            d.dat = {24'h00_0000, q.protect_pin_enable, 3'b000, ~|q.plr, 1'b0, q.io_config_bit, 1'b0};
         end else if (wb_adr_i == `FPHS_OFF_CTRL) begin
            d.dat = {27'h000_0000, q.psus, q.esus, q.busy, q.write_enable_latch, q.quad};
         end else if (wb_adr_i == `FPHS_OFF_BPM_LO) begin
            d.dat = bpm_eff[31:0];
         end else if (wb_adr_i == `FPHS_OFF_BPM_HI) begin
            d.dat = {16'h0000, bpm_eff[47:32]};
         end else if (wb_adr_i == `FPHS_OFF_PLR_LO) begin
            d.dat = q.plr[31:0];
         end else if (wb_adr_i == `FPHS_OFF_PLR_HI) begin
            d.dat = {24'h00_0000, q.plr[39:32]};
         end else if (wb_adr_i == `FPHS_OFF_UID_ADDR) begin
            d.dat = {21'h00_0000, q.uid_addr};
         end else if (wb_adr_i == `FPHS_OFF_UID_DATA) begin
            d.dat = {24'h00_0000, uid_rd};
         end else if (wb_adr_i == `FPHS_OFF_RESULT) begin
            d.dat = {31'h0000_0000, q.refused};
         end else begin
            d.dat = 32'h0000_0000;
         end
      end
      if (commit) begin
         if (wb_adr_i == `FPHS_OFF_RESULT) begin
            d.refused = 1'b0;
         end else if (wb_adr_i == `FPHS_OFF_CFG) begin
            if (hw_prot) begin
               d.refused = 1'b1; // [R12]
            end else if (wb_sel_i[0]) begin
               d.io_config_bit = wb_dat_i[`FPHS_CFG_IOC]; // [R12]
               d.protect_pin_enable = wb_dat_i[`FPHS_CFG_PROTECT_PIN_ENABLE]; // [R8]
            end
         end else if (wb_adr_i == `FPHS_OFF_CTRL) begin
            if (wb_sel_i[0]) begin
               d.quad = wb_dat_i[`FPHS_CTRL_QUAD];
               d.write_enable_latch = wb_dat_i[`FPHS_CTRL_WEL];
               d.busy = wb_dat_i[`FPHS_CTRL_BUSY];
               d.esus = wb_dat_i[`FPHS_CTRL_ESUS];
               d.psus = wb_dat_i[`FPHS_CTRL_PSUS];
            end
         end else if (wb_adr_i == `FPHS_OFF_CMD) begin
            if (wb_sel_i[0] && wb_dat_i[`FPHS_CMD_LOCKDOWN]) begin
               d.lockdown = 1'b1; // [R23]
            end
            if (wb_sel_i[0] && wb_dat_i[`FPHS_CMD_LOCK_UID]) begin
               d.uid_lock = 1'b1; // [R15]
            end
            if (wb_sel_i[0] && wb_dat_i[`FPHS_CMD_ERASE_UID]) begin
               d.refused = 1'b1; // [R16]
            end
         end else if (wb_adr_i == `FPHS_OFF_BPM_LO || wb_adr_i == `FPHS_OFF_BPM_HI) begin
            if (q.lockdown || hw_prot) begin
               d.refused = 1'b1; // [R11] [R13]
            end else if (wb_adr_i == `FPHS_OFF_BPM_LO) begin
               d.bpm[31:0] = (q.bpm[31:0] & ~wmask) | (wb_dat_i & wmask) | plr_map[31:0]; // [R2]
            end else begin
               d.bpm[47:32] = (q.bpm[47:32] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0])
                              | plr_map[47:32]; // [R2]
            end
         end else if (wb_adr_i == `FPHS_OFF_PLR_LO || wb_adr_i == `FPHS_OFF_PLR_HI) begin
            if (q.lockdown) begin
               d.refused = 1'b1; // [R5]
            end else if (wb_adr_i == `FPHS_OFF_PLR_LO) begin
               d.plr[31:0] = q.plr[31:0] | (wb_dat_i & wmask); // [R3] [R4]
            end else if (wb_sel_i[0]) begin
               d.plr[39:32] = q.plr[39:32] | wb_dat_i[7:0]; // [R3] [R4]
            end
         end else if (wb_adr_i == `FPHS_OFF_UID_ADDR) begin
            if (wb_sel_i[0]) begin
               d.uid_addr[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               d.uid_addr[10:8] = wb_dat_i[10:8];
            end
         end else if (wb_adr_i == `FPHS_OFF_UID_DATA) begin
            if (wb_sel_i[0] && !uid_prog_ok) begin
               d.refused = 1'b1; // [R14] [R15]
            end
         end
      end
      // Pause is entered and resumed only on a sampled low clock, so an edge during high waits for the low phase; deselect aborts at once.
      case (q.hst)
         FPHS_H_RUN: begin
            if (hold_en && !s_cs_n && !s_hold_n && !s_sck) begin
               d.hst = FPHS_H_PAUSE; // [R17] [R18]
            end
         end
         FPHS_H_PAUSE: begin
            if (s_cs_n) begin
               d.hst = FPHS_H_ABORT; // [R20]
               d.lreset = 1'b1; // [R20]
            end else if (s_hold_n && !s_sck) begin
               d.hst = FPHS_H_RUN; // [R18]
            end
         end
         FPHS_H_ABORT: begin
            if (s_hold_n && s_cs_n) begin
               d.hst = FPHS_H_RUN; // [R20]
            end
         end
         default: begin
            d.hst = FPHS_H_RUN;
         end
      endcase
      d.hiz = d.hst != FPHS_H_RUN; // [R19]
      d.active = d.hst == FPHS_H_RUN && !s_cs_n; // [R19]
   end

   // Persistent fields are left alone by rst_i; only nv_init_i returns them to factory state.
   always_ff @(posedge clk_i) begin
      if (nv_init_i) begin
         q.plr <= `FPHS_PLR_RST; // [R24]
         q.protect_pin_enable <= `FPHS_PROTECT_PIN_ENABLE_RST; // [R8] [R24]
         q.uid_lock <= 1'b0;
      end else begin
         q.plr <= d.plr;
         q.protect_pin_enable <= d.protect_pin_enable;
         q.uid_lock <= d.uid_lock;
      end
      if (rst_i) begin
         q.ack <= 1'b0;
         q.dat <= 32'h0000_0000;
         q.bpm <= `FPHS_BPM_RST;
         q.lockdown <= 1'b0; // [R23] [R24]
         q.io_config_bit <= 1'b0;
         q.quad <= 1'b0;
         q.write_enable_latch <= 1'b0;
         q.busy <= 1'b0;
         q.esus <= 1'b0;
         q.psus <= 1'b0;
         q.refused <= 1'b0;
         q.uid_addr <= 11'h000;
         q.hst <= FPHS_H_RUN;
         q.hiz <= 1'b0;
         q.active <= 1'b0;
         q.lreset <= 1'b0;
         q.hwp <= 1'b0;
      end else begin
         q.ack <= d.ack;
         q.dat <= d.dat;
         q.bpm <= d.bpm;
         q.lockdown <= d.lockdown;
         q.io_config_bit <= d.io_config_bit;
         q.quad <= d.quad;
         q.write_enable_latch <= d.write_enable_latch;
         q.busy <= d.busy;
         q.esus <= d.esus;
         q.psus <= d.psus;
         q.refused <= d.refused;
         q.uid_addr <= d.uid_addr;
         q.hst <= d.hst;
         q.hiz <= d.hiz;
         q.active <= d.active;
         q.lreset <= d.lreset;
         q.hwp <= d.hwp;
      end
   end

   // Programming can only clear bits, as in the array; factory init leaves the space erased.
   always_ff @(posedge clk_i) begin
      if (nv_init_i) begin
         for (int i = 0; i < `FPHS_UID_BYTES; i++) begin
            uid_mem[i] <= `FPHS_UID_ERASED; // [R24]
         end
      end else if (uid_prog_ok) begin
         uid_mem[q.uid_addr] <= uid_mem[q.uid_addr] & wb_dat_i[7:0]; // [R14]
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign so_hiz_o = q.hiz;
   assign link_active_o = q.active;
   assign logic_reset_o = q.lreset;
   assign hw_protect_o = q.hwp;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || nv_init_i);

   sequence s_pause_entry;
      q.hst == FPHS_H_RUN ##1 q.hst == FPHS_H_PAUSE;
   endsequence

   sequence s_abort_pulse;
      logic_reset_o ##1 !logic_reset_o;
   endsequence

   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_plr_never_clears: assert property ((q.plr & $past(q.plr)) == $past(q.plr)) // [R3]
      else $error("permanent lock bit cleared");
   a_map_follows_plr: assert property (##1 (q.bpm & $past(plr_map)) == $past(plr_map)) // [R2]
      else $error("write-lock bit not forced by permanent lock");
   a_plr_lockdown_hold: assert property (q.lockdown && commit && wb_adr_i == `FPHS_OFF_PLR_LO
      |=> $stable(q.plr) && q.refused) // [R5]
      else $error("permanent lock changed under lock-down");
   a_map_pin_block: assert property (hw_prot && commit && wb_adr_i == `FPHS_OFF_BPM_LO
      |=> q.bpm[31:0] == ($past(q.bpm[31:0]) | $past(plr_map[31:0]))) // [R11]
      else $error("map written while pin protects");
   a_map_lockdown_block: assert property (q.lockdown && commit && wb_adr_i == `FPHS_OFF_BPM_HI
      |=> q.bpm[47:32] == ($past(q.bpm[47:32]) | $past(plr_map[47:32]))) // [R13]
      else $error("map written under lock-down");
   a_cfg_pin_block: assert property (hw_prot && commit && wb_adr_i == `FPHS_OFF_CFG
      |=> $stable({q.io_config_bit, q.protect_pin_enable})) // [R12]
      else $error("configuration written while protected");
   a_uid_locked_refuse: assert property (q.uid_lock && commit && wb_adr_i == `FPHS_OFF_UID_DATA
      |=> q.refused) // [R15]
      else $error("identifier program not refused after lock");
   a_status_busy_pair: assert property (status[0] == status[7] && !status[6]) // [R21] [R22]
      else $error("status busy bits disagree");
   a_pause_clock_low: assert property (s_pause_entry |-> !$past(s_sck) && $past(hold_en)) // [R17] [R18]
      else $error("pause entered outside clock-low or in quad");
   a_abort_resets: assert property (q.hst == FPHS_H_PAUSE && s_cs_n |=> s_abort_pulse) // [R20]
      else $error("deselect during pause did not reset logic");
endmodule
`default_nettype wire

// *** hw/fphs_defines.svh ***
// Purpose: Offsets, field positions, reset values and sizes of the flash protection block.
// Assumes: Included by the package and by the design files by its bare name.
// Notes: Definitions only.
`ifndef FPHS_DEFINES_SVH
`define FPHS_DEFINES_SVH

`define FPHS_OFF_STATUS 8'h00
`define FPHS_OFF_CFG 8'h04
`define FPHS_OFF_CTRL 8'h08
`define FPHS_OFF_CMD 8'h0C
`define FPHS_OFF_BPM_LO 8'h10
`define FPHS_OFF_BPM_HI 8'h14
`define FPHS_OFF_PLR_LO 8'h18
`define FPHS_OFF_PLR_HI 8'h1C
`define FPHS_OFF_UID_ADDR 8'h20
`define FPHS_OFF_UID_DATA 8'h24
`define FPHS_OFF_RESULT 8'h28

`define FPHS_CFG_IOC 1
`define FPHS_CFG_BPNV 3
`define FPHS_CFG_PROTECT_PIN_ENABLE 7
`define FPHS_CTRL_QUAD 0
`define FPHS_CTRL_WEL 1
`define FPHS_CTRL_BUSY 2
`define FPHS_CTRL_ESUS 3
`define FPHS_CTRL_PSUS 4
`define FPHS_CMD_LOCKDOWN 0
`define FPHS_CMD_LOCK_UID 1
`define FPHS_CMD_ERASE_UID 2

`define FPHS_PLR_W 40
`define FPHS_BPM_W 48
`define FPHS_PARAM_BLOCKS 8
`define FPHS_UID_BYTES 2048
`define FPHS_UID_AW 11
`define FPHS_UID_FACTORY_BYTES 11'h008
`define FPHS_SYNC_W 4

`define FPHS_BPM_RST 48'hFFFF_FFFF_5555
`define FPHS_PLR_RST 40'h00_0000_0000
`define FPHS_PROTECT_PIN_ENABLE_RST 1'b0
`define FPHS_SYNC_RST 4'b1110
`define FPHS_UID_ERASED 8'hFF

`endif

// *** hw/fphs_pkg.sv ***
// Purpose: Types shared by the flash protection block.
// Assumes: The defines header supplies all sizes.
// Notes: Holds the state records and the pause state encoding.
`include "fphs_defines.svh"

package fphs_pkg;

   typedef enum logic [1:0] {
      FPHS_H_RUN = 2'b00,
      FPHS_H_PAUSE = 2'b01,
      FPHS_H_ABORT = 2'b10
   } fphs_hold_t;

   typedef struct packed {
      logic [`FPHS_SYNC_W-1:0] meta;
      logic [`FPHS_SYNC_W-1:0] out;
   } fphs_sync_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic [`FPHS_BPM_W-1:0] bpm;
      logic [`FPHS_PLR_W-1:0] plr;
      logic lockdown;
      logic protect_pin_enable;
      logic io_config_bit;
      logic uid_lock;
      logic quad;
      logic write_enable_latch;
      logic busy;
      logic esus;
      logic psus;
      logic refused;
      logic [`FPHS_UID_AW-1:0] uid_addr;
      fphs_hold_t hst;
      logic hiz;
      logic active;
      logic lreset;
      logic hwp;
   } fphs_state_t;

endpackage

// *** hw/fphs_sync.sv ***
// Purpose: Two-stage synchroniser for the serial link pins.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
`include "fphs_defines.svh"

module fphs_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`FPHS_SYNC_W-1:0] async_i,
   output logic [`FPHS_SYNC_W-1:0] sync_o
);
   import fphs_pkg::*;

   fphs_sync_t q;
   fphs_sync_t d;

   always_comb begin
      d = q;
      d.meta = async_i;
      d.out = q.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q.meta <= `FPHS_SYNC_RST;
         q.out <= `FPHS_SYNC_RST;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.out;
endmodule
`default_nettype wire

// *** tb/fphs_host_model.sv ***
// Purpose: Host-side model that drives the serial link pins of the flash protection block.
// Assumes: The bench raises frame_i to select the device and pause_i to request a pause.
// Notes: The serial clock runs at 200 ns only inside a frame and rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module fphs_host_model (
   input wire logic frame_i,
   input wire logic pause_i,
   input wire logic wp_low_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic hold_n_o,
   output logic wp_n_o
);
   initial sck_o = 1'b0;
   // A deselected host parks the clock low, so the device never sees stray edges.
   always begin
      #100;
      sck_o = cs_n_o ? 1'b0 : ~sck_o;
   end
   assign cs_n_o = ~frame_i;
   assign hold_n_o = ~pause_i;
   assign wp_n_o = ~wp_low_i;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the flash protection, pause and status block.
// Assumes: Classic Wishbone master on a 40 MHz clock; host model drives the link pins.
// Notes: Persistent storage is cleared by nv_init_i only where a scenario needs a clean part.
`timescale 1ns/1ps
`default_nettype none
`include "fphs_defines.svh"
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, nv_init_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic wb_ack_o, so_hiz_o, link_active_o, logic_reset_o, hw_protect_o;
   logic [31:0] wb_dat_o;
   logic sck_i, cs_n_i, hold_n_i, wp_n_i;
   logic frame = 1'b0, pause = 1'b0, wp_low = 1'b0;
   int n_fail = 0, samples_checked = 0;
   wire logic [2:0] lk = {link_active_o, logic_reset_o, so_hiz_o};
   always #12.5 clk_i = ~clk_i;
   fphs_top #(.UNIQUE_ID(64'hFEDC_BA98_7654_3210)) u_fphs_top (.clk_i(clk_i), .rst_i(rst_i), .nv_init_i(nv_init_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sck_i(sck_i),
      .cs_n_i(cs_n_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_hiz_o(so_hiz_o),
      .link_active_o(link_active_o), .logic_reset_o(logic_reset_o), .hw_protect_o(hw_protect_o));
   fphs_host_model u_fphs_host_model (.frame_i(frame), .pause_i(pause), .wp_low_i(wp_low),
      .sck_o(sck_i), .cs_n_o(cs_n_i), .hold_n_o(hold_n_i), .wp_n_o(wp_n_i));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Only the watchdog ends a wait for the acknowledge.
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0000_0000, r);
      chk(r, e);
   endtask
   task automatic power(input logic nv);
      @(posedge clk_i);
      rst_i <= 1'b1;
      nv_init_i <= nv;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      nv_init_i <= 1'b0;
   endtask
   // Bounded wait on one link output; a one-cycle pulse is still caught at its edge.
   task automatic wait_lk(input int k, input logic v);
      int n;
      n = 0;
      while (lk[k] !== v && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      chk({31'h0, lk[k]}, {31'h0, v});
   endtask
   task automatic t_reset;
      rd(`FPHS_OFF_STATUS, 32'h0000_0000);
      rd(`FPHS_OFF_CFG, 32'h0000_0008);
      rd(`FPHS_OFF_BPM_LO, 32'hFFFF_5555);
      rd(`FPHS_OFF_PLR_LO, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
      wr(`FPHS_OFF_CTRL, 32'h0000_001A);
      rd(`FPHS_OFF_CTRL, 32'h0000_001A);
      rd(`FPHS_OFF_STATUS, 32'h0000_000E);
      wr(`FPHS_OFF_CTRL, 32'h0000_0000);
   endtask
   task automatic t_perm;
      wr(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      wr(`FPHS_OFF_BPM_HI, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      wr(`FPHS_OFF_PLR_LO, 32'h0001_0003);
      rd(`FPHS_OFF_BPM_LO, 32'h0100_0005);
      wr(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_LO, 32'h0100_0005);
      wr(`FPHS_OFF_PLR_LO, 32'h0000_0000);
      rd(`FPHS_OFF_PLR_LO, 32'h0001_0003);
      wr(`FPHS_OFF_PLR_LO, 32'h0000_0004);
      rd(`FPHS_OFF_PLR_LO, 32'h0001_0007);
      wr(`FPHS_OFF_PLR_HI, 32'h0000_00FF);
      rd(`FPHS_OFF_BPM_HI, 32'h0000_FF00);
      power(1'b0);
      rd(`FPHS_OFF_PLR_LO, 32'h0001_0007);
      power(1'b1);
   endtask
   task automatic t_lockdown;
      wr(`FPHS_OFF_CMD, 32'h0000_0001);
      rd(`FPHS_OFF_STATUS, 32'h0000_0010);
      wr(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_LO, 32'hFFFF_5555);
      rd(`FPHS_OFF_RESULT, 32'h0000_0001);
      wr(`FPHS_OFF_BPM_HI, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_HI, 32'h0000_FFFF);
      wr(`FPHS_OFF_PLR_LO, 32'h0000_0001);
      rd(`FPHS_OFF_PLR_LO, 32'h0000_0000);
      wr(`FPHS_OFF_CFG, 32'h0000_0002);
      rd(`FPHS_OFF_CFG, 32'h0000_000A);
      power(1'b0);
      rd(`FPHS_OFF_STATUS, 32'h0000_0000);
   endtask
   task automatic t_hwprot;
      wr(`FPHS_OFF_CFG, 32'h0000_0080);
      wp_low <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk({31'h0, hw_protect_o}, 32'h0000_0001);
      wr(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_LO, 32'hFFFF_5555);
      wr(`FPHS_OFF_CFG, 32'h0000_0000);
      rd(`FPHS_OFF_CFG, 32'h0000_0088);
      wr(`FPHS_OFF_CTRL, 32'h0000_0004);
      rd(`FPHS_OFF_STATUS, 32'h0000_0081);
      wr(`FPHS_OFF_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk_i);
      chk({31'h0, hw_protect_o}, 32'h0000_0000);
      wr(`FPHS_OFF_CTRL, 32'h0000_0000);
      wp_low <= 1'b0;
      wr(`FPHS_OFF_CFG, 32'h0000_0082);
      wp_low <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk({31'h0, hw_protect_o}, 32'h0000_0000);
      wr(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      power(1'b0);
      rd(`FPHS_OFF_CFG, 32'h0000_0088);
      wp_low <= 1'b0;
      wr(`FPHS_OFF_CFG, 32'h0000_0000);
      wp_low <= 1'b1;
      repeat (4) @(posedge clk_i);
      wr(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      rd(`FPHS_OFF_BPM_LO, 32'h0000_0000);
      wp_low <= 1'b0;
   endtask
   task automatic t_uid;
      wr(`FPHS_OFF_UID_ADDR, 32'h0000_0003);
      wr(`FPHS_OFF_UID_DATA, 32'h0000_0000);
      rd(`FPHS_OFF_UID_DATA, 32'h0000_0076);
      rd(`FPHS_OFF_RESULT, 32'h0000_0001);
      wr(`FPHS_OFF_RESULT, 32'h0000_0000);
      wr(`FPHS_OFF_UID_ADDR, 32'h0000_0008);
      wr(`FPHS_OFF_UID_DATA, 32'h0000_005A);
      rd(`FPHS_OFF_UID_DATA, 32'h0000_005A);
      wr(`FPHS_OFF_CMD, 32'h0000_0004);
      rd(`FPHS_OFF_UID_DATA, 32'h0000_005A);
      wr(`FPHS_OFF_CMD, 32'h0000_0002);
      rd(`FPHS_OFF_STATUS, 32'h0000_0020);
      wr(`FPHS_OFF_UID_ADDR, 32'h0000_0009);
      wr(`FPHS_OFF_UID_DATA, 32'h0000_0000);
      rd(`FPHS_OFF_UID_DATA, 32'h0000_00FF);
      power(1'b0);
      rd(`FPHS_OFF_STATUS, 32'h0000_0020);
   endtask
   task automatic t_hold;
      frame <= 1'b1;
      wait_lk(2, 1'b1);
      pause <= 1'b1;
      wait_lk(0, 1'b1);
      chk({31'h0, link_active_o}, 32'h0000_0000);
      pause <= 1'b0;
      wait_lk(0, 1'b0);
      wr(`FPHS_OFF_CTRL, 32'h0000_0001);
      pause <= 1'b1;
      repeat (24) @(posedge clk_i);
      chk({31'h0, so_hiz_o}, 32'h0000_0000);
      pause <= 1'b0;
      wr(`FPHS_OFF_CTRL, 32'h0000_0000);
      pause <= 1'b1;
      wait_lk(0, 1'b1);
      frame <= 1'b0;
      wait_lk(1, 1'b1);
      pause <= 1'b0;
      wait_lk(0, 1'b0);
      frame <= 1'b1;
      wait_lk(2, 1'b1);
      frame <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      nv_init_i <= 1'b0;
      t_reset();
      t_perm();
      t_lockdown();
      t_hwprot();
      power(1'b1);
      t_uid();
      t_hold();
      report_and_stop();
   end
endmodule
`default_nettype wire
